//--- design/swc_pkg.sv
package swc_pkg;

   typedef enum logic [3:0] {
      SWC_RUN = 4'b0001,
      SWC_HALT = 4'b0010,
      SWC_EXEC = 4'b0100,
      SWC_VECTOR = 4'b1000
   } swc_state_type;

endpackage

//--- design/swc_regs.svh
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

// Register indexes; the byte address is four times the index.
`define SWC_IDX_OPTION 16'h0081
`define SWC_IDX_CONFIG 16'h2007
`define SWC_IDX_STATUS 16'h0003
`define SWC_IDX_WAKE_EN 16'h0010
`define SWC_IDX_WAKE_FLAG 16'h0011
`define SWC_IDX_WDT 16'h0012

// Register reset values.
`define SWC_OPTION_RST 8'hff
`define SWC_CONFIG_RST 8'hff
`define SWC_WAKE_EN_RST 8'h00

// Field positions.
`define SWC_OPT_PSA 3
`define SWC_OPT_PS_LSB 0
`define SWC_OPT_PS_MSB 2
`define SWC_CFG_WATCHDOG_CONFIG_ENABLE 2
`define SWC_STAT_PD 3
`define SWC_STAT_TO 4
`define SWC_STAT_STATE_LSB 8
`define SWC_STAT_STATE_MSB 11
`define SWC_WDT_PRE_LSB 16

// Wake sources: bit 0 external pin, bit 1 port change, bits 7:2 peripherals.
`define SWC_NSRC 8
`define SWC_NPERIPH 6
`define SWC_PIN_SRC_CAPABLE 2'b11

// Interrupt vector and bus responses.
`define SWC_VECTOR_ADDR 13'h0004
`define SWC_RESP_OKAY 2'b00
`define SWC_RESP_SLVERR 2'b10

`endif

//--- design/swc_top.sv
`timescale 1ns/1ps
`include "swc_regs.svh"
// Summary of operation
// - Halt with watchdog enabled clears its count; watchdog keeps running.
// - Entering halt clears power-down flag and sets time-out flag.
// - Oscillator driver is off while halted.
// - Every I/O pin keeps its drive state during halt.
// - Halt ends on master clear, watchdog time-out, or enabled wake interrupt.
// - Master clear gives full reset; other wakes resume without reset.
// - Watchdog wake from halt clears the time-out flag.
// - Only the listed clock-free peripheral interrupts can wake from halt.
// - Peripherals needing core clock phases raise no interrupts while halted.
// - Halt prefetches the instruction at the following address.
// - Wake needs the source enable; global enable does not matter.
// - Global enable clear continues in line; set runs next then vectors.
// - Halt with an enabled flag already set acts as no-operation.
// - Interrupt during halt completes the halt, then wakes immediately (here a flag in the halt cycle makes it a no-operation).
// - Watchdog clear zeroes prescaler count when assigned to the watchdog, keeps prescaler assignment.
// - Time-out resets in normal operation, wakes while halted.
module swc_top #(
   parameter int ADDR_W = 16,
   parameter int IO_W = 8,
   parameter int WDT_W = 8,
   parameter int PRE_W = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic master_clear_pin_n,
   input wire logic halt_instr,
   input wire logic watchdog_clear_instr,
   input wire logic global_irq_enable,
   input wire logic [`SWC_NSRC-1:0] irq_flag,
   input wire logic [`SWC_NPERIPH-1:0] periph_clockless,
   input wire logic wdt_osc_tick,
   input wire logic [IO_W-1:0] core_io_out,
   input wire logic [IO_W-1:0] core_io_oe,
   output logic [IO_W-1:0] io_out,
   output logic [IO_W-1:0] io_oe,
   output logic osc_drive_en,
   output swc_pkg::swc_state_type halt_state,
   output logic prefetch_req,
   output logic resume,
   output logic vector_req,
   output logic [12:0] vector_addr,
   output logic device_reset,
   output logic power_down_flag,
   output logic timeout_flag
);
   import swc_pkg::*;

   localparam logic [ADDR_W-1:0] A_OPTION = ADDR_W'({`SWC_IDX_OPTION, 2'b00});
   localparam logic [ADDR_W-1:0] A_CONFIG = ADDR_W'({`SWC_IDX_CONFIG, 2'b00});
   localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'({`SWC_IDX_STATUS, 2'b00});
   localparam logic [ADDR_W-1:0] A_WAKE_EN = ADDR_W'({`SWC_IDX_WAKE_EN, 2'b00});
   localparam logic [ADDR_W-1:0] A_WAKE_FLAG = ADDR_W'({`SWC_IDX_WAKE_FLAG, 2'b00});
   localparam logic [ADDR_W-1:0] A_WDT = ADDR_W'({`SWC_IDX_WDT, 2'b00});
   swc_state_type state_r, state_nxt;
   logic [7:0] option_r, config_r, wake_en_r, w_byte_r;
   logic master_clear_pin, watchdog_config_enable, run_st, halt_st, pending, wake;
   logic halt_do, wdt_run_reset, wdt_wake, dev_reset, wdt_clear, wdt_timeout;
   logic [WDT_W-1:0] wdt_count;
   logic [PRE_W-1:0] pre_count;
   logic aw_have_r, w_have_r, w_lane0_r, do_write, rd_hit;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] rd_data;
   assign master_clear_pin = !master_clear_pin_n;
   assign watchdog_config_enable = config_r[`SWC_CFG_WATCHDOG_CONFIG_ENABLE];
   assign run_st = (state_r == SWC_RUN);
   assign halt_st = (state_r == SWC_HALT);

   swc_wake_gate #(
      .NSRC(`SWC_NSRC)
   ) u_gate (
      .irq_flag(irq_flag),
      .irq_enable(wake_en_r),
      .wake_capable({periph_clockless, `SWC_PIN_SRC_CAPABLE}),
      .halted(halt_st),
      .pending(pending),
      .wake(wake)
   );
   swc_watchdog #(
      .CNT_W(WDT_W),
      .PRE_W(PRE_W)
   ) u_wdt (
      .sys_clk(sys_clk),
      .rst(rst),
      .osc_tick(wdt_osc_tick),
      .enable(watchdog_config_enable),
      .clear(wdt_clear),
      .pre_assign(option_r[`SWC_OPT_PSA]),
      .pre_sel(option_r[`SWC_OPT_PS_MSB:`SWC_OPT_PS_LSB]),
      .count(wdt_count),
      .pre_count(pre_count),
      .timeout(wdt_timeout)
   );
   // Outside halt a time-out is a reset; in halt it is a wake.
   assign wdt_run_reset = !halt_st && watchdog_config_enable && wdt_timeout;
   assign wdt_wake = halt_st && watchdog_config_enable && wdt_timeout && !master_clear_pin;
   assign dev_reset = master_clear_pin || wdt_run_reset;
   // A flag already armed turns the halt into a no-operation.
   assign halt_do = run_st && halt_instr && !pending && !dev_reset;
   assign wdt_clear = halt_do || (watchdog_clear_instr && !halt_st && !dev_reset);
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SWC_RUN: begin
            if (halt_do) begin
               state_nxt = SWC_HALT;
            end
         end
         SWC_HALT: begin
            // An interrupt arriving with the halt makes it a no-operation, so it is never seen here.
            if (wake && global_irq_enable) begin
               state_nxt = SWC_EXEC;
            end else if (wake || wdt_wake) begin
               state_nxt = SWC_RUN;
            end
         end
         SWC_EXEC: begin
            state_nxt = SWC_VECTOR;
         end
         SWC_VECTOR: begin
            state_nxt = SWC_RUN;
         end
         default: begin
            state_nxt = SWC_RUN;
         end
      endcase
      if (dev_reset) begin
         state_nxt = SWC_RUN;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= SWC_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end
   // The state is exported straight from its flop.
   assign halt_state = state_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prefetch_req <= 1'b0;
         resume <= 1'b0;
         vector_req <= 1'b0;
         vector_addr <= 13'h0000;
         device_reset <= 1'b0;
      end else begin
         prefetch_req <= halt_do;
         resume <= halt_st && (state_nxt != SWC_HALT) && !dev_reset;
         vector_req <= (state_r == SWC_EXEC) && !dev_reset;
         // Same vector as an ordinary interrupt entry.
         vector_addr <= ((state_r == SWC_EXEC) && !dev_reset) ? `SWC_VECTOR_ADDR : 13'h0000;
         device_reset <= dev_reset;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osc_drive_en <= 1'b1;
      end else begin
         osc_drive_en <= (state_nxt != SWC_HALT);
      end
   end

   // Pins freeze from the halt cycle on, so they show the drive from before it.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         io_out <= '0;
         io_oe <= '0;
      end else if (!halt_st && (state_nxt != SWC_HALT)) begin
         io_out <= core_io_out;
         io_oe <= core_io_oe;
      end
   end

   // The time-out event wins over a set in the same cycle.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end else if (wdt_run_reset || wdt_wake) begin
         timeout_flag <= 1'b0;
      end else if (halt_do) begin
         power_down_flag <= 1'b0;
         timeout_flag <= 1'b1;
      end else if (watchdog_clear_instr && run_st && !dev_reset) begin
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end
   end

   // Write path: address and data are taken in either order.
   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_have_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         w_have_r <= 1'b0;
         w_byte_r <= 8'h00;
         w_lane0_r <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         w_byte_r <= s_axi_wdata[7:0];
         w_lane0_r <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_have_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SWC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if ((aw_addr_r == A_OPTION) || (aw_addr_r == A_CONFIG) || (aw_addr_r == A_WAKE_EN)) begin
            s_axi_bresp <= `SWC_RESP_OKAY;
         end else begin
            s_axi_bresp <= `SWC_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // A device reset restores the option register like power-on does.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         option_r <= `SWC_OPTION_RST;
      end else if (dev_reset) begin
         option_r <= `SWC_OPTION_RST;
      end else if (do_write && w_lane0_r && (aw_addr_r == A_OPTION)) begin
         option_r <= w_byte_r;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         config_r <= `SWC_CONFIG_RST;
         wake_en_r <= `SWC_WAKE_EN_RST;
      end else if (do_write && w_lane0_r) begin
         if (aw_addr_r == A_CONFIG) begin
            config_r <= w_byte_r;
         end else if (aw_addr_r == A_WAKE_EN) begin
            wake_en_r <= w_byte_r;
         end
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      if (s_axi_araddr == A_OPTION) begin
         rd_data[7:0] = option_r;
      end else if (s_axi_araddr == A_CONFIG) begin
         rd_data[7:0] = config_r;
      end else if (s_axi_araddr == A_STATUS) begin
         rd_data[`SWC_STAT_PD] = power_down_flag;
         rd_data[`SWC_STAT_TO] = timeout_flag;
         rd_data[`SWC_STAT_STATE_MSB:`SWC_STAT_STATE_LSB] = state_r;
      end else if (s_axi_araddr == A_WAKE_EN) begin
         rd_data[7:0] = wake_en_r;
      end else if (s_axi_araddr == A_WAKE_FLAG) begin
         rd_data[7:0] = irq_flag;
      end else if (s_axi_araddr == A_WDT) begin
         rd_data[WDT_W-1:0] = wdt_count;
         rd_data[`SWC_WDT_PRE_LSB +: PRE_W] = pre_count;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SWC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_hit ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   sequence s_irq_wake;
      halt_st && wake && global_irq_enable && !master_clear_pin;
   endsequence
   sequence s_exec_then_vector;
      (state_r == SWC_EXEC) ##1 (vector_req && vector_addr == `SWC_VECTOR_ADDR);
   endsequence
   chk_halt_clears_wdt: assert property (halt_do && watchdog_config_enable |=> wdt_count == '0)
      else $error("watchdog count not cleared by halt");
   chk_halt_flags: assert property (halt_do |=> !power_down_flag && timeout_flag)
      else $error("halt entry flags wrong");
   chk_osc_off: assert property (halt_st |-> !osc_drive_en)
      else $error("oscillator driver on while halted");
   chk_io_hold: assert property (halt_st && $past(halt_st) |-> $stable(io_out) && $stable(io_oe))
      else $error("pins changed during halt");
   chk_master_clear_pin_reset: assert property (master_clear_pin |=> device_reset && !halt_st)
      else $error("master clear gave no reset");
   chk_wdt_wake_flag: assert property (wdt_wake |=> !timeout_flag && !device_reset)
      else $error("watchdog wake handled wrong");
   chk_prefetch_next: assert property (halt_do |=> prefetch_req)
      else $error("no prefetch on halt");
   chk_wake_any_gie: assert property (halt_st && wake && !master_clear_pin |=> !halt_st ##0 resume)
      else $error("enabled source did not wake");
   chk_vector_path: assert property (s_irq_wake |=> s_exec_then_vector)
      else $error("wake with global enable did not vector");
   chk_inline_path: assert property (halt_st && wake && !global_irq_enable && !master_clear_pin
      |=> run_st ##1 !vector_req)
      else $error("wake without global enable vectored");
   chk_nop_halt: assert property (run_st && halt_instr && pending && !dev_reset
      |=> run_st && $stable(power_down_flag) && !prefetch_req)
      else $error("halt with pending flag took effect");
   chk_run_timeout: assert property (wdt_run_reset |=> device_reset ##1 !timeout_flag)
      else $error("time-out in run gave no reset");
endmodule // swc_top

//--- design/swc_wake_gate.sv
`timescale 1ns/1ps
`include "swc_regs.svh"
module swc_wake_gate #(
   parameter int NSRC = `SWC_NSRC
) (
   input wire logic [NSRC-1:0] irq_flag,
   input wire logic [NSRC-1:0] irq_enable,
   input wire logic [NSRC-1:0] wake_capable,
   input wire logic halted,
   output logic pending,
   output logic wake
);
   logic [NSRC-1:0] armed;
   logic [NSRC-1:0] qual;

   genvar i;
   generate
      for (i = 0; i < NSRC; i++) begin : g_src
         // A source only counts once its own enable is set.
         assign armed[i] = irq_flag[i] & irq_enable[i];
         // Sources that need core clock phases are ignored while halted.
         assign qual[i] = armed[i] & (wake_capable[i] | ~halted);
      end
   endgenerate

   assign pending = |armed;
   // Global enable plays no part in waking.
   assign wake = halted & (|qual);
endmodule // swc_wake_gate

//--- design/swc_watchdog.sv
`timescale 1ns/1ps
module swc_watchdog #(
   parameter int CNT_W = 8,
   parameter int PRE_W = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic osc_tick,
   input wire logic enable,
   input wire logic clear,
   input wire logic pre_assign,
   input wire logic [2:0] pre_sel,
   output logic [CNT_W-1:0] count,
   output logic [PRE_W-1:0] pre_count,
   output logic timeout
);
   logic [PRE_W-1:0] mask;
   logic tick_out;

   always_comb begin
      mask = (PRE_W'(1) << pre_sel) - PRE_W'(1);
      tick_out = osc_tick && (!pre_assign || ((pre_count & mask) == mask));
   end

   // The count keeps running on its own tick regardless of the core state.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count <= '0;
         pre_count <= '0;
      end else if (!enable) begin
         count <= '0;
         pre_count <= '0;
      end else if (clear) begin
         count <= '0;
         // The assignment bit itself is left alone.
         if (pre_assign) begin
            pre_count <= '0;
         end
      end else begin
         if (osc_tick && pre_assign) begin
            pre_count <= pre_count + PRE_W'(1);
         end
         if (tick_out) begin
            count <= count + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timeout <= 1'b0;
      end else begin
         timeout <= enable && !clear && tick_out && (&count);
      end
   end
endmodule // swc_watchdog

//--- testbench/sleep_wake_controller_tb.sv
`timescale 1ns/1ps
`include "swc_regs.svh"
module sleep_wake_controller_tb;
   import swc_pkg::*;
   localparam logic [15:0] A_OPT = 16'(`SWC_IDX_OPTION * 4);
   localparam logic [15:0] A_CFG = 16'(`SWC_IDX_CONFIG * 4);
   localparam logic [15:0] A_STAT = 16'(`SWC_IDX_STATUS * 4);
   localparam logic [15:0] A_EN = 16'(`SWC_IDX_WAKE_EN * 4);
   localparam logic [15:0] A_WDT = 16'(`SWC_IDX_WDT * 4);
   localparam logic [1:0] OK = `SWC_RESP_OKAY;
   localparam logic [1:0] ERR = `SWC_RESP_SLVERR;
   logic sys_clk;
   logic rst;
   logic [15:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [15:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic master_clear_pin_n;
   logic halt_instr;
   logic watchdog_clear_instr;
   logic global_irq_enable;
   logic [7:0] irq_flag;
   logic [5:0] periph_clockless;
   logic wdt_osc_tick;
   logic [7:0] core_io_out;
   logic [7:0] core_io_oe;
   logic [7:0] io_out;
   logic [7:0] io_oe;
   logic osc_drive_en;
   swc_state_type halt_state;
   logic prefetch_req;
   logic resume;
   logic vector_req;
   logic [12:0] vector_addr;
   logic device_reset;
   logic power_down_flag;
   logic timeout_flag;
   int n_fail = 0;
   int checked = 0;
   int n_rst = 0;
   int n_res = 0;
   int cyc = 0;
   int k;
   int m;
   logic [31:0] rd;

   swc_top #(.WDT_W(2)) dut_u (.*);
   swc_core_model core_u (.*);

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (device_reset === 1'b1) n_rst <= n_rst + 1;
      if (resume === 1'b1) n_res <= n_res + 1;
      if (cyc == 5000) begin
         n_fail = n_fail + 1;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      // Ready drops once an address or data beat is taken and rises again only after the response handshake completes.
      chk(32'(s_axi_bresp), 32'(r));
   endtask

   task automatic axi_rd(input logic [15:0] a, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      chk(32'(s_axi_rresp), 32'(r));
   endtask

   task automatic t_reset();
      axi_rd(A_OPT, OK);
      chk(rd, 32'h0000_00ff);
      axi_rd(A_CFG, OK);
      chk(rd, 32'h0000_00ff);
      axi_rd(A_STAT, OK);
      chk(rd & 32'h0f18, 32'h0118);
      axi_rd(16'h0100, ERR);
      chk(rd, 32'h0);
      axi_wr(A_STAT, 32'h0, ERR);
      chk(32'(osc_drive_en), 32'h1);
   endtask

   task automatic t_inline();
      axi_wr(A_EN, 32'h03, OK);
      core_io_out <= 8'h5a;
      core_io_oe <= 8'h0f;
      step();
      core_u.sleep_seq();
      #1;
      chk(32'(halt_state), 32'(SWC_HALT));
      chk(32'(osc_drive_en), 32'h0);
      chk(32'(prefetch_req), 32'h1);
      chk(32'({power_down_flag, timeout_flag}), 32'h1);
      core_io_out <= 8'ha5;
      core_io_oe <= 8'hf0;
      axi_rd(A_WDT, OK);
      chk(rd & 32'h3, 32'h0);
      chk(32'({io_oe, io_out}), 32'h0f5a);
      irq_flag <= 8'h01;
      step();
      chk(32'(halt_state), 32'(SWC_RUN));
      chk(32'({resume, vector_req, device_reset}), 32'h4);
      irq_flag <= 8'h00;
      step();
      step();
      chk(32'(io_out), 32'ha5);
   endtask

   task automatic t_vector();
      global_irq_enable <= 1'b1;
      core_u.sleep_seq();
      #1;
      irq_flag <= 8'h02;
      step();
      chk(32'(halt_state), 32'(SWC_EXEC));
      chk(32'({power_down_flag, timeout_flag, resume}), 32'h3);
      step();
      chk(32'(halt_state), 32'(SWC_VECTOR));
      chk(32'({vector_req, vector_addr}), 32'(14'h2004));
      step();
      chk(32'({halt_state, vector_addr}), 32'(17'h02000));
      irq_flag <= 8'h00;
      global_irq_enable <= 1'b0;
   endtask

   task automatic t_nop();
      irq_flag <= 8'h01;
      step();
      core_u.sleep_seq();
      #1;
      chk(32'(halt_state), 32'(SWC_RUN));
      chk(32'({prefetch_req, power_down_flag, timeout_flag}), 32'h3);
      irq_flag <= 8'h00;
   endtask

   task automatic t_prescaler();
      axi_wr(A_OPT, 32'h0b, OK);
      core_u.ticks(3);
      axi_rd(A_WDT, OK);
      chk(32'(rd[23:16]), 32'h3);
      core_u.clr();
      axi_rd(A_WDT, OK);
      chk(rd & 32'h00ff_0003, 32'h0);
      axi_rd(A_OPT, OK);
      chk(rd, 32'h0b);
   endtask

   task automatic t_blocked();
      axi_wr(A_EN, 32'h0c, OK);
      periph_clockless <= 6'b111110;
      core_u.sleep_seq();
      #1;
      irq_flag <= 8'h05;
      step();
      step();
      chk(32'(halt_state), 32'(SWC_HALT));
      irq_flag <= 8'h0d;
      step();
      chk(32'(halt_state), 32'(SWC_RUN));
      irq_flag <= 8'h00;
      step();
      core_u.sleep_seq();
      #1;
      master_clear_pin_n <= 1'b0;
      step();
      chk(32'({device_reset, resume}), 32'h2);
      chk(32'(halt_state), 32'(SWC_RUN));
      master_clear_pin_n <= 1'b1;
      axi_rd(A_OPT, OK);
      chk(rd, 32'hff);
   endtask

   task automatic t_wdt();
      axi_wr(A_OPT, 32'h08, OK);
      k = n_rst;
      repeat (10) if (n_rst == k) core_u.ticks(1);
      #1;
      chk(32'(n_rst > k), 32'h1);
      chk(32'(timeout_flag), 32'h0);
      axi_wr(A_OPT, 32'h08, OK);
      core_u.sleep_seq();
      k = n_res;
      m = n_rst;
      repeat (10) if (n_res == k) core_u.ticks(1);
      #1;
      chk(32'({n_res > k, n_rst == m}), 32'h3);
      chk(32'(timeout_flag), 32'h0);
      chk(32'(halt_state), 32'(SWC_RUN));
   endtask

   initial begin
      rst = 1'b1;
      s_axi_awaddr = 16'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 16'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      master_clear_pin_n = 1'b1;
      global_irq_enable = 1'b0;
      irq_flag = 8'h00;
      periph_clockless = 6'h3f;
      core_io_out = 8'h00;
      core_io_oe = 8'h00;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      step();
      t_reset();
      t_inline();
      t_vector();
      t_nop();
      t_prescaler();
      t_blocked();
      t_wdt();
      summarize();
   end
endmodule // sleep_wake_controller_tb

//--- testbench/swc_core_model.sv
`timescale 1ns/1ps
module swc_core_model (
   input wire logic sys_clk,
   output logic halt_instr,
   output logic watchdog_clear_instr,
   output logic wdt_osc_tick
);
   initial begin
      halt_instr = 1'b0;
      watchdog_clear_instr = 1'b0;
      wdt_osc_tick = 1'b0;
   end

   task automatic clr();
      watchdog_clear_instr <= 1'b1;
      @(posedge sys_clk);
      watchdog_clear_instr <= 1'b0;
   endtask

   // Clearing the watchdog first means a halt never starts on a nearly expired count.
   task automatic sleep_seq();
      clr();
      halt_instr <= 1'b1;
      @(posedge sys_clk);
      halt_instr <= 1'b0;
   endtask

   // The watchdog oscillator only ticks when asked, so no time-out happens by accident.
   task automatic ticks(input int n);
      repeat (n) begin
         wdt_osc_tick <= 1'b1;
         @(posedge sys_clk);
         wdt_osc_tick <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
endmodule // swc_core_model
